// ===== hw/dbgtr_params.svh
// timing and field constants of the debug trace block
`ifndef DBGTR_PARAMS_SVH
`define DBGTR_PARAMS_SVH
`define DBGTR_CLK_PERIOD_NS 40
`define DBGTR_TAG_HI 31
`define DBGTR_TAG_LO 11
`define DBGTR_IDX_HI 10
`define DBGTR_IDX_LO 4
`define DBGTR_SEL_HI 12
`define DBGTR_SEL_LO 11
`define DBGTR_WSEL_HI 3
`define DBGTR_WSEL_LO 2
`define DBGTR_ALIGN_ZERO 2'h0
`define DBGTR_RSVD_VALUE 2'h0
`define DBGTR_BUF_DEPTH 2
`endif

// ===== hw/dbgtr_pkg.sv
// types of the debug trace block
package dbgtr_pkg;
    typedef enum logic [1:0] {
        dbgtr_miss_idle,
        dbgtr_miss_armed,
        dbgtr_miss_wait_read
    } dbgtr_miss_e;
    typedef logic [31:0] dbgtr_word_t;
endpackage

// ===== hw/dbgtr_core.sv
// debug mode address display and forced instruction cache miss logic
`include "dbgtr_params.svh"

// Notes on behaviour
// - debug select high enables debug mode, while running and during reset.
// - in debug mode, idle bus cycles show fetch address, no address latch strobe.
// - index captured first, tag half a cycle later, then concatenated.
// - bus 31:11 tag 31:11, 10:4 index 10:4, 3:2 index 12:11.
// - bus 1:0 reserved; word-select lines 3:2 carry index 3:2.
// - instruction fetch index bits 1:0 are always zero.
// - coarse trace only; write/DMA branches may drop, no exception marker.
// - address shown during internal stalls may be wrong; flagged not valid.
// - forced-miss sampled on falling edge in debug mode; next fetch misses.
// - forced-miss never alters the valid bit written on refill.
module dbgtr_core (
    // clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,

    // debug pins
    input wire logic debug_select,
    input wire logic forced_miss,

    // instruction cache lookup
    input wire logic fetch_valid,
    input wire logic [12:0] cache_index_bits,
    input wire logic [31:0] cache_tag,
    input wire logic internal_stall,

    // bus interface state
    input wire logic bus_idle,
    input wire logic bus_read_start,
    input wire logic [31:0] bus_ad_core,
    input wire logic [3:2] bus_wsel_core,
    input wire logic bus_ale_core,

    // cache refill
    input wire logic refill_valid_in,
    output logic refill_valid_out,

    // miss request towards fetch unit
    input wire logic fetch_taken,
    output logic force_miss_req,

    // multiplexed bus pins
    output logic [31:0] ad_out,
    output logic [3:2] wsel_out,
    output logic ale,
    output logic debug_active,
    output logic display_valid,

    // trace word stream
    output logic trace_valid,
    input wire logic trace_ready,
    output logic [31:0] trace_data
);
    // fetch address capture, rising edge index and falling edge tag
    logic [12:0] idx_q;
    logic [12:0] next_idx_q;
    logic [31:0] tag_q;
    logic [31:0] next_tag_q;

    // forced-miss sample and request state
    logic jam_fall;
    logic next_jam_fall;
    dbgtr_pkg::dbgtr_miss_e miss_st;
    dbgtr_pkg::dbgtr_miss_e next_miss_st;

    // registered bus pins
    logic [31:0] ad_q;
    logic [31:0] next_ad_q;
    logic [3:2] wsel_q;
    logic [3:2] next_wsel_q;
    logic ale_q;
    logic next_ale_q;

    // display qualifiers, registered with the bus word
    logic disp_q;
    logic next_disp_q;
    logic dbg_q;
    logic next_dbg_q;

    // two-entry trace buffer
    dbgtr_pkg::dbgtr_word_t buf_mem [0:`DBGTR_BUF_DEPTH-1];
    dbgtr_pkg::dbgtr_word_t next_buf_mem [0:`DBGTR_BUF_DEPTH-1];
    logic wr_ptr;
    logic next_wr_ptr;
    logic rd_ptr;
    logic next_rd_ptr;
    logic [1:0] count;
    logic [1:0] next_count;

    // combinational helpers
    logic display_now;
    dbgtr_pkg::dbgtr_word_t shown_word;
    logic push;
    logic pop;
    logic buf_ready;

    // debug select is a level: it works in reset too, so it is not gated by rst
    assign debug_active = debug_select;

    // index is sampled on the rising edge, tag on the falling edge after it
    always_comb begin
        next_idx_q = idx_q;
        if (fetch_valid) begin
            next_idx_q = {cache_index_bits[12:2], `DBGTR_ALIGN_ZERO};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            idx_q <= 13'h0000;
        end else if (clk_en) begin
            idx_q <= next_idx_q;
        end
    end

    always_comb begin
        next_tag_q = cache_tag;
    end

    // gating by select here keeps a jam pin left high outside debug mode harmless
    always_comb begin
        next_jam_fall = forced_miss && debug_select;
    end

    // falling-edge capture keeps the half-cycle offset of the tag response
    always_ff @(negedge clock) begin
        if (rst) begin
            tag_q <= 32'h0000_0000;
        end else if (clk_en) begin
            tag_q <= next_tag_q;
        end
    end

    // jam pin margins are loose, so it is taken mid-cycle, away from the rising edge
    always_ff @(negedge clock) begin
        if (rst) begin
            jam_fall <= 1'b0;
        end else if (clk_en) begin
            jam_fall <= next_jam_fall;
        end
    end

    always_comb begin
        shown_word = 32'h0000_0000;
        shown_word[`DBGTR_TAG_HI:`DBGTR_TAG_LO] = tag_q[`DBGTR_TAG_HI:`DBGTR_TAG_LO];
        shown_word[`DBGTR_IDX_HI:`DBGTR_IDX_LO] = idx_q[`DBGTR_IDX_HI:`DBGTR_IDX_LO];
        shown_word[3:2] = idx_q[`DBGTR_SEL_HI:`DBGTR_SEL_LO];
        shown_word[1:0] = `DBGTR_RSVD_VALUE;
    end

    assign display_now = debug_select && bus_idle;

    // bus pins; ale stays low on display cycles so bus state machines do not start
    always_comb begin
        next_ad_q = bus_ad_core;
        next_wsel_q = bus_wsel_core;
        next_ale_q = bus_ale_core;
        next_dbg_q = debug_select;
        next_disp_q = 1'b0;
        if (display_now) begin
            next_ad_q = shown_word;
            next_wsel_q = idx_q[`DBGTR_WSEL_HI:`DBGTR_WSEL_LO];
            next_ale_q = 1'b0;
            // stalls give a stale address; only a coarse trace is offered
            next_disp_q = !internal_stall;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ad_q <= 32'h0000_0000;
            wsel_q <= 2'h0;
            ale_q <= 1'b0;
        end else if (clk_en) begin
            ad_q <= next_ad_q;
            wsel_q <= next_wsel_q;
            ale_q <= next_ale_q;
        end
    end

    // qualifiers travel with the word so the flag always matches what is on the pins
    always_ff @(posedge clock) begin
        if (rst) begin
            disp_q <= 1'b0;
            dbg_q <= 1'b0;
        end else if (clk_en) begin
            disp_q <= next_disp_q;
            dbg_q <= next_dbg_q;
        end
    end

    assign ad_out = ad_q;
    assign wsel_out = wsel_q;
    assign ale = ale_q;
    assign display_valid = disp_q && dbg_q;

    // forced miss: armed by a falling-edge sample, served by the next fetch
    always_comb begin
        next_miss_st = miss_st;
        case (miss_st)
            dbgtr_pkg::dbgtr_miss_idle: begin
                if (jam_fall && debug_select) begin
                    next_miss_st = dbgtr_pkg::dbgtr_miss_armed;
                end
            end
            dbgtr_pkg::dbgtr_miss_armed: begin
                if (!debug_select) begin
                    next_miss_st = dbgtr_pkg::dbgtr_miss_idle;
                end else if (fetch_taken) begin
                    next_miss_st = dbgtr_pkg::dbgtr_miss_wait_read;
                end
            end
            dbgtr_pkg::dbgtr_miss_wait_read: begin
                // a pin still high after the read re-arms, hence the advice to drop it early
                if (bus_read_start || !debug_select) begin
                    next_miss_st = dbgtr_pkg::dbgtr_miss_idle;
                end
            end
            default: begin
                next_miss_st = dbgtr_pkg::dbgtr_miss_idle;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            miss_st <= dbgtr_pkg::dbgtr_miss_idle;
        end else if (clk_en) begin
            miss_st <= next_miss_st;
        end
    end

    assign force_miss_req = (miss_st == dbgtr_pkg::dbgtr_miss_armed);
    assign refill_valid_out = refill_valid_in;

    // two-entry trace buffer; words shown while full are dropped, as the trace is coarse
    assign buf_ready = (count != 2'h2);
    assign push = display_valid && buf_ready;
    assign pop = trace_valid && trace_ready;

    always_comb begin
        next_buf_mem = buf_mem;
        if (push) begin
            next_buf_mem[wr_ptr] = ad_q;
        end
    end

    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        if (push) begin
            next_wr_ptr = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
    end

    // a push and a pop in one cycle leave the fill level unchanged
    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 2'h1;
        end else if (pop && !push) begin
            next_count = count - 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            buf_mem[0] <= 32'h0000_0000;
            buf_mem[1] <= 32'h0000_0000;
        end else if (clk_en) begin
            buf_mem <= next_buf_mem;
        end
    end

    // pointers and level freeze together with the words when the clock enable is low
    always_ff @(posedge clock) begin
        if (rst) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else if (clk_en) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    assign trace_valid = (count != 2'h0);
    assign trace_data = buf_mem[rd_ptr];
endmodule // dbgtr_core

// ===== verification/dbgtr_monitor.sv
// assertion checker for the debug trace block ports
module dbgtr_monitor (
    // clock and control
    input wire logic clock,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic debug_select,
    input wire logic internal_stall,
    input wire logic bus_idle,
    input wire logic fetch_taken,
    input wire logic refill_valid_in,
    // outputs watched
    input wire logic refill_valid_out,
    input wire logic force_miss_req,
    input wire logic [31:0] ad_out,
    input wire logic ale,
    input wire logic debug_active,
    input wire logic display_valid
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence req_held;
        clk_en && debug_select && force_miss_req && !fetch_taken;
    endsequence
    sequence req_taken;
        clk_en && force_miss_req && fetch_taken;
    endsequence
    chk_mode_follows: assert property (debug_active == debug_select)
        else $error("debug active differs from select");
    chk_display_on: assert property (
        clk_en && debug_select && bus_idle && !internal_stall |=> display_valid)
        else $error("idle cycle in debug mode without display");
    chk_ale_quiet: assert property (display_valid |-> !ale)
        else $error("strobe raised on display cycle");
    chk_low_bits_zero: assert property (display_valid |-> ad_out[1:0] == 2'h0)
        else $error("reserved bus bits not zero");
    chk_stall_flag: assert property (clk_en && internal_stall |=> !display_valid)
        else $error("stall cycle flagged valid");
    chk_mode_off: assert property (
        clk_en && !debug_select |=> !display_valid && !force_miss_req)
        else $error("display or miss while debug mode off");
    chk_req_stands: assert property (req_held |=> force_miss_req)
        else $error("miss request dropped before taken");
    chk_req_drops: assert property (req_taken |=> !force_miss_req)
        else $error("miss request kept after taken");
    chk_refill_pass: assert property (refill_valid_out == refill_valid_in)
        else $error("refill valid bit altered");
endmodule // dbgtr_monitor

bind dbgtr_core dbgtr_monitor dbgtr_monitor_inst (.clock(clock), .rst(rst), .clk_en(clk_en),
    .debug_select(debug_select), .internal_stall(internal_stall), .bus_idle(bus_idle),
    .fetch_taken(fetch_taken), .refill_valid_in(refill_valid_in),
    .refill_valid_out(refill_valid_out), .force_miss_req(force_miss_req), .ad_out(ad_out),
    .ale(ale), .debug_active(debug_active), .display_valid(display_valid));

// ===== verification/dbgtr_trace_model.sv
// trace and jam logic model facing the debug trace block
module dbgtr_trace_model (
    // clock and commands
    input wire logic clock,
    input wire logic rst,
    input wire logic jam_req,
    input wire logic hold_off,
    // device side
    input wire logic bus_read_start,
    input wire logic display_valid,
    input wire logic [31:0] ad_out,
    output logic forced_miss,
    output logic trace_ready,
    output logic [31:0] last_addr
);
    timeunit 1ns;
    timeprecision 1ns;
    logic rd, jr, ho, after_read;
    initial begin
        forced_miss = 1'b0;
        trace_ready = 1'b1;
        after_read = 1'b0;
    end
    always @(posedge clock) begin
        rd = bus_read_start;
        jr = jam_req;
        ho = hold_off;
        // latch on the clock edge, the strobe stays low; skip the cycle after a read
        if (display_valid && !after_read) last_addr = ad_out;
        after_read = rd;
        // change well clear of the falling sample edge
        #5;
        trace_ready = !ho;
        if (rst || rd) forced_miss = 1'b0;
        else if (jr) forced_miss = 1'b1;
    end
endmodule // dbgtr_trace_model

// ===== verification/dbgtr_core_tb.sv
// self-checking bench for the debug trace block
module dbgtr_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [12:0] idx; logic [31:0] tag; logic st; logic [31:0] ad;
        logic [3:2] ws;} dbgtr_row_s;
    logic clock = 0, rst = 1, clk_en = 1, debug_select = 1, fetch_valid = 0;
    logic internal_stall = 0, bus_idle = 0, bus_read_start = 0, bus_ale_core = 0;
    logic refill_valid_in = 0, fetch_taken = 0, jam_req = 0, hold_off = 0;
    logic forced_miss, trace_ready, refill_valid_out, force_miss_req;
    logic ale, debug_active, display_valid, trace_valid;
    logic [12:0] cache_index_bits = 13'h0;
    logic [31:0] cache_tag = 32'h0, bus_ad_core = 32'h0, ad_out, trace_data, last_addr;
    logic [3:2] bus_wsel_core = 2'h0, wsel_out;
    int err_count = 0, checked = 0, cycles = 0;
    dbgtr_row_s rows [5] = '{'{13'h1FFC, 32'h0, 0, 32'h7FC, 2'h3},
        '{13'h0, 32'hFFFFFFFF, 0, 32'hFFFFF800, 2'h0}, '{13'h1003, 32'h7FF, 0, 32'h8, 2'h0},
        '{13'h0804, 32'h12345800, 1, 32'h0, 2'h0}, '{13'h0804, 32'h12345800, 0, 32'h12345804, 2'h1}};
    dbgtr_core dbgtr_core_inst (.clock(clock), .rst(rst), .clk_en(clk_en),
        .debug_select(debug_select), .forced_miss(forced_miss), .fetch_valid(fetch_valid),
        .cache_index_bits(cache_index_bits), .cache_tag(cache_tag),
        .internal_stall(internal_stall), .bus_idle(bus_idle), .bus_read_start(bus_read_start),
        .bus_ad_core(bus_ad_core), .bus_wsel_core(bus_wsel_core), .bus_ale_core(bus_ale_core),
        .refill_valid_in(refill_valid_in), .refill_valid_out(refill_valid_out),
        .fetch_taken(fetch_taken), .force_miss_req(force_miss_req), .ad_out(ad_out),
        .wsel_out(wsel_out), .ale(ale), .debug_active(debug_active),
        .display_valid(display_valid), .trace_valid(trace_valid), .trace_ready(trace_ready),
        .trace_data(trace_data));
    dbgtr_trace_model dbgtr_trace_model_inst (.clock(clock), .rst(rst), .jam_req(jam_req),
        .hold_off(hold_off), .bus_read_start(bus_read_start), .display_valid(display_valid),
        .ad_out(ad_out), .forced_miss(forced_miss), .trace_ready(trace_ready),
        .last_addr(last_addr));
    initial begin
        forever #20 clock = !clock;
    end
    task automatic step(int n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 600) begin
            err_count++;
            final_report;
        end
    end
    initial begin
        step(12);
        chk("debug_active", debug_active, 1);
        chk("ad_out", ad_out, 0);
        rst = 0;
        foreach (rows[i]) begin
            {bus_idle, fetch_valid, internal_stall} = {2'h3, rows[i].st};
            {cache_index_bits, cache_tag} = {rows[i].idx, rows[i].tag};
            step(3);
            chk("display_valid", display_valid, !rows[i].st);
            if (!rows[i].st) chk("ad_out", ad_out, rows[i].ad);
            if (!rows[i].st) chk("wsel_out", wsel_out, rows[i].ws);
            if (!rows[i].st) chk("ale", ale, 0);
            $display("test row %0d done", i);
        end
        {debug_select, jam_req} = 2'h1;
        step(4);
        chk("force_miss_req", force_miss_req, 0);
        chk("display_valid", display_valid, 0);
        {debug_select, jam_req, refill_valid_in} = 3'h5;
        step(2);
        chk("force_miss_req", force_miss_req, 1);
        chk("refill_valid_out", refill_valid_out, 1);
        fetch_taken = 1;
        step(1);
        fetch_taken = 0;
        chk("force_miss_req", force_miss_req, 0);
        bus_read_start = 1;
        step(1);
        bus_read_start = 0;
        step(1);
        chk("forced_miss", forced_miss, 0);
        $display("test jam done");
        {bus_idle, bus_ale_core, bus_ad_core, bus_wsel_core} = {2'h1, 32'hA5C3_0F18, 2'h2};
        step(3);
        chk("trace_valid", trace_valid, 0);
        chk("ad_out", ad_out, 32'hA5C30F18);
        chk("wsel_out", wsel_out, 2'h2);
        chk("ale", ale, 1);
        bus_ale_core = 0;
        {hold_off, bus_idle} = 2'h3;
        step(6);
        chk("trace_valid", trace_valid, 1);
        chk("trace_data", trace_data, 32'h12345804);
        chk("last_addr", last_addr, 32'h12345804);
        {hold_off, bus_idle} = 2'h0;
        step(4);
        chk("trace_valid", trace_valid, 0);
        $display("test buffer done");
        final_report;
    end
endmodule // dbgtr_core_tb
